// *** common/vts_pkg.sv ***
// Purpose: shared constants and types for the voltage transformer supervision block
// Assumes: 100 MHz system clock, 5 ms program cycle marked by a tick input
// Notes: angles are in units of 0.01 degree, times in milliseconds
package vts_pkg;
	// clock and time base
	localparam int CLK_NS = 10; // system clock period in ns
	localparam int MS_NS = 1000000; // one millisecond in ns
	localparam int CLK_PER_MS = MS_NS / CLK_NS; // clocks per millisecond
	localparam int CYCLE_MS = 5; // program cycle length in ms
	localparam int ANGLE_LAG_MS = 40; // angle comparison distance in ms
	localparam int LAG_DEPTH = ANGLE_LAG_MS / CYCLE_MS; // program cycles between compared angles
	localparam int HIST_DEPTH = 12; // history records kept
	localparam int NUM_FAM = 6; // event families, each with on and off
	localparam int NUM_EVT = 2 * NUM_FAM; // event codes in total
	// widths and limits
	localparam int VMAG_W = 16; // voltage magnitude width
	localparam int TS_W = 40; // time stamp width in ms
	localparam int REM_W = 21; // remaining time width in ms
	localparam logic [REM_W-1:0] MAX_DELAY_MS = 21'h1B_7740; // 1800 s ceiling
	localparam logic [15:0] ANGLE_FULL = 16'h8CA0; // 360.00 deg
	localparam logic [15:0] ANGLE_HALF = 16'h4650; // 180.00 deg
	// event families: code = 2*family + (1 for off)
	localparam logic [3:0] EVT_START_ON = 4'h0;
	localparam logic [3:0] EVT_OPER_ON = 4'h2; // bus operate
	localparam logic [3:0] EVT_BLOCK_ON = 4'h4; // bus block
	localparam logic [3:0] EVT_LFAIL_ON = 4'h6; // line failure
	localparam logic [3:0] EVT_BFUSE_ON = 4'h8; // bus fuse failure
	localparam logic [3:0] EVT_LFUSE_ON = 4'hA; // line fuse failure
	// per-voltage status
	localparam logic [1:0] VST_NONE = 2'h0; // no voltage
	localparam logic [1:0] VST_OK = 2'h1; // voltage ok
	localparam logic [1:0] VST_LOW = 2'h2; // low voltage
	// system status
	localparam logic [2:0] SYS_DEAD = 3'h0; // bus dead
	localparam logic [2:0] SYS_OK = 3'h1; // live, sequence ok (+1 rev, +2 undef)
	localparam logic [2:0] SYS_FAULT = 3'h4; // live, supervision fault
	// encoded condition
	localparam logic [2:0] COND_NORMAL = 3'h0;
	localparam logic [2:0] COND_START = 3'h1; // start or operate
	localparam logic [2:0] COND_LINEFAIL = 3'h2; // line failure
	localparam logic [2:0] COND_BUSFAIL = 3'h3; // bus fuse failure
	localparam logic [2:0] COND_BLOCKED = 3'h4; // blocked
	// event and history record
	typedef struct packed {
		logic [TS_W-1:0] ts; // ms time stamp
		logic [3:0] code; // event code
		logic [5:0] vstat; // three 2-bit voltage states
		logic [2:0] sys; // system status
		logic [15:0] angle; // angle difference 0..36000
		logic [REM_W-1:0] remain; // ms left to operate
		logic [2:0] grp; // setting group minus one
	} hist_rec_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_OPERATE, ST_BLOCK} vts_state_t;
endpackage

// *** common/hist_if.sv ***
// Purpose: carrier between supervision core and its record history
// Assumes: both ends on clk_sys_i
// Notes: write is a one-cycle strobe, read is index 0 = newest
`timescale 1ns/10ps
interface hist_if;
	logic wr_en; // store one record
	vts_pkg::hist_rec_t wr_rec; // record to store
	logic [3:0] rd_idx; // age of record to read
	vts_pkg::hist_rec_t rd_rec; // registered read data
	logic [3:0] count; // records held
	modport writer (output wr_en, output wr_rec, output rd_idx, input rd_rec, input count);
	modport store (input wr_en, input wr_rec, input rd_idx, output rd_rec, output count);
endinterface

// *** rtl/vts_history.sv ***
// Purpose: ring of the most recent operation records
// Assumes: at most one write per clock
// Notes: oldest record is overwritten once full
`timescale 1ns/10ps
module vts_history #(
	parameter int DEPTH = vts_pkg::HIST_DEPTH // records kept
) (
	input wire logic clk_sys_i, // system clock
	input wire logic reset_i, // synchronous reset
	hist_if.store h // record port
);
	vts_pkg::hist_rec_t mem_r [DEPTH]; // record storage
	logic [3:0] ptr_r, ptr_nxt; // next slot to write
	logic [3:0] cnt_r, cnt_nxt; // records held
	vts_pkg::hist_rec_t rd_r, rd_nxt; // read data
	int pos; // slot of requested record

	// pointer, fill level and read selection
	always_comb begin
		pos = 0;
		ptr_nxt = ptr_r;
		cnt_nxt = cnt_r;
		if (h.wr_en) begin
			ptr_nxt = (int'(ptr_r) == DEPTH - 1) ? 4'h0 : ptr_r + 4'h1; // wrap drops oldest
			if (int'(cnt_r) < DEPTH) begin
				cnt_nxt = cnt_r + 4'h1;
			end
		end
		pos = int'(ptr_r) - 1 - int'(h.rd_idx);
		if (pos < 0) begin
			pos = pos + DEPTH;
		end
		rd_nxt = '0;
		if (h.rd_idx < cnt_r) begin
			rd_nxt = mem_r[pos];
		end
	end

	// register state and write the array
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ptr_r <= 4'h0;
			cnt_r <= 4'h0;
			rd_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
		end
		if (h.wr_en) begin
			mem_r[ptr_r] <= h.wr_rec;
		end
	end

	assign h.rd_rec = rd_r;
	assign h.count = cnt_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_hist_bound: assert property (int'(cnt_r) <= DEPTH) else $error("history over capacity");
	a_hist_on_only: assert property (h.wr_en |-> !h.wr_rec.code[0]) else $error("off event recorded");
	a_hist_grow: assert property (h.wr_en && int'(cnt_r) < DEPTH |=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("history count not advanced");
	c_hist_full: cover property (h.wr_en && int'(cnt_r) == DEPTH);
endmodule

// *** rtl/vts_top.sv ***
// Purpose: blocking, start gating, definite delay and event logging of transformer supervision
// Assumes: cycle_tick_i pulses once per program cycle; inputs synchronous to clk_sys_i
// Notes: release is immediate; events drain one per clock, lowest code first
// Functional notes
// - blocking sampled once per program cycle
// - pick-up without blocking asserts start, starts delay
// - pick-up while blocked asserts blocked only
// - blocking drops active start like pick-up reset
// - blocking gives display note and event
// - definite time delay only
// - events on changes, per-edge storage select
// - every event time stamped with process data
// - twelve on/off event codes, six families
// - history keeps twelve latest records
// - history written on on-transitions only
// - record fields: time, event, states, angle, remaining, group
// - pick-up: one low or two high
// - small angle change over 40 ms blocks pick-up
// - condition code: normal, start, line, bus, blocked
`timescale 1ns/10ps
module vts_top #(
	parameter int CLK_PER_MS = vts_pkg::CLK_PER_MS, // clocks per ms, shorten in simulation
	parameter int LAG = vts_pkg::LAG_DEPTH // program cycles in the angle comparison
) (
	input wire logic clk_sys_i, // system clock
	input wire logic reset_i, // synchronous reset, high
	input wire logic cycle_tick_i, // program cycle start pulse
	input wire logic blk_i, // blocking input from matrix
	input wire logic [2:0][vts_pkg::VMAG_W-1:0] volt_mag_i, // three voltage magnitudes
	input wire logic [vts_pkg::VMAG_W-1:0] low_thr_i, // low pick-up level
	input wire logic [vts_pkg::VMAG_W-1:0] high_thr_i, // high detect level
	input wire logic [15:0] angle_i, // present angle, 0.01 deg
	input wire logic [15:0] angle_limit_i, // angle shift limit, 0.01 deg
	input wire logic [vts_pkg::REM_W-1:0] delay_ms_i, // definite operating delay
	input wire logic line_fail_i, // line transformer failure
	input wire logic bus_fuse_i, // bus fuse tripped
	input wire logic line_fuse_i, // line fuse tripped
	input wire logic bus_fuse_chk_i, // supervise bus fuse
	input wire logic line_fuse_chk_i, // supervise line fuse
	input wire logic [1:0] seq_code_i, // 0 ok, 1 reversed, 2 undefined
	input wire logic [2:0] setting_group_index_i, // active group minus one
	input wire logic [vts_pkg::NUM_EVT-1:0] evt_sel_i, // store enable per event code
	input wire logic [3:0] hist_rd_idx_i, // history age to read
	output logic start_o, // start output
	output logic operate_o, // operate output
	output logic blocked_o, // blocked output
	output logic display_note_o, // display notification pulse
	output logic [2:0] condition_o, // encoded condition
	output logic [vts_pkg::REM_W-1:0] remaining_ms_o, // time left to operate
	output logic evt_valid_o, // event to main buffer
	output vts_pkg::hist_rec_t evt_rec_o, // event record
	output vts_pkg::hist_rec_t hist_rec_o, // history read data
	output logic [3:0] hist_count_o // records held
);
	hist_if hif(); // link to history
	vts_pkg::vts_state_t st_r, st_nxt; // supervision state
	logic [vts_pkg::REM_W-1:0] rem_r, rem_nxt; // delay countdown
	logic [vts_pkg::NUM_FAM-1:0] act_r, act_nxt; // level of each event family
	logic [vts_pkg::NUM_EVT-1:0] pend_r, pend_nxt; // events waiting to issue
	logic [vts_pkg::NUM_EVT-1:0] clr; // event taken this clock
	logic [3:0] sel; // lowest pending code
	logic note_r, note_nxt; // display pulse
	logic [2:0] cond_r, cond_nxt; // condition code
	vts_pkg::hist_rec_t snap_r, snap_nxt; // process data at last evaluation
	vts_pkg::hist_rec_t evt_r, evt_nxt; // issued event
	logic evt_v_r, evt_v_nxt; // issued event valid
	logic [31:0] ms_cnt_r, ms_cnt_nxt; // clock divider
	logic [vts_pkg::TS_W-1:0] ts_r, ts_nxt; // ms time stamp
	logic ms_tick; // one clock per ms
	logic [15:0] lag_r [LAG]; // angle history per cycle
	logic [15:0] d_raw, ang_diff; // angle changes
	logic [5:0] vstat; // per-voltage status
	logic [1:0] high_cnt; // voltages above high level
	logic low_any, pickup; // pick-up terms

	// classify one voltage
	function automatic logic [1:0] volt_state(input logic [vts_pkg::VMAG_W-1:0] v,
		input logic [vts_pkg::VMAG_W-1:0] lo);
		if (v == '0) begin
			return vts_pkg::VST_NONE;
		end else if (v < lo) begin
			return vts_pkg::VST_LOW;
		end
		return vts_pkg::VST_OK;
	endfunction

	// millisecond time base and time stamp
	always_comb begin
		ms_tick = (int'(ms_cnt_r) == CLK_PER_MS - 1);
		ms_cnt_nxt = ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h0000_0001;
		ts_nxt = ms_tick ? ts_r + 40'h00_0000_0001 : ts_r;
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ms_cnt_r <= 32'h0000_0000;
			ts_r <= '0;
		end else begin
			ms_cnt_r <= ms_cnt_nxt;
			ts_r <= ts_nxt;
		end
	end

	// angle samples, one per program cycle; stage 0 takes the live angle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			lag_r[0] <= 16'h0000;
		end else if (cycle_tick_i) begin
			lag_r[0] <= angle_i;
		end
	end

	// older samples shift one stage per tick, no stage reads below index 0
	for (genvar g = 1; g < LAG; g++) begin : g_lag
		always_ff @(posedge clk_sys_i) begin
			if (reset_i) begin
				lag_r[g] <= 16'h0000;
			end else if (cycle_tick_i) begin
				lag_r[g] <= lag_r[g-1];
			end
		end
	end

	// pick-up evaluation
	always_comb begin
		high_cnt = 2'h0;
		low_any = 1'b0;
		for (int i = 0; i < 3; i++) begin
			vstat[2*i +: 2] = volt_state(volt_mag_i[i], low_thr_i);
			low_any = low_any | (volt_mag_i[i] < low_thr_i);
			high_cnt = high_cnt + {1'b0, volt_mag_i[i] > high_thr_i};
		end
		d_raw = (angle_i >= lag_r[LAG-1]) ? angle_i - lag_r[LAG-1] : lag_r[LAG-1] - angle_i;
		ang_diff = (d_raw > vts_pkg::ANGLE_HALF) ? vts_pkg::ANGLE_FULL - d_raw : d_raw;
		pickup = (low_any || high_cnt >= 2'h2) && !(ang_diff < angle_limit_i);
	end

	// event selection: lowest pending code goes first
	always_comb begin
		sel = 4'h0;
		for (int i = vts_pkg::NUM_EVT - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				sel = 4'(i);
			end
		end
		clr = '0;
		clr[sel] = pend_r[sel];
		hif.wr_en = pend_r[sel] && !sel[0];
		hif.wr_rec = snap_r;
		hif.wr_rec.code = sel;
		hif.rd_idx = hist_rd_idx_i;
		evt_nxt = evt_r;
		evt_v_nxt = pend_r[sel] && evt_sel_i[sel];
		if (pend_r[sel]) begin
			evt_nxt = snap_r;
			evt_nxt.code = sel;
		end
	end

	// supervision state, delay and event capture
	always_comb begin
		st_nxt = st_r;
		rem_nxt = rem_r;
		act_nxt = act_r;
		note_nxt = 1'b0;
		snap_nxt = snap_r;
		pend_nxt = pend_r & ~clr;
		cond_nxt = cond_r;
		if (st_r == vts_pkg::ST_START && ms_tick && rem_r != '0) begin
			rem_nxt = rem_r - 21'h00_0001;
		end
		if (cycle_tick_i) begin
			// blk_i is read only here, once per cycle
			case (st_r)
				vts_pkg::ST_IDLE: begin
					if (pickup && blk_i) begin
						st_nxt = vts_pkg::ST_BLOCK;
						note_nxt = 1'b1;
					end else if (pickup) begin
						st_nxt = vts_pkg::ST_START;
						rem_nxt = (delay_ms_i > vts_pkg::MAX_DELAY_MS) ? vts_pkg::MAX_DELAY_MS : delay_ms_i;
					end
				end
				vts_pkg::ST_START, vts_pkg::ST_OPERATE: begin
					if (blk_i) begin
						st_nxt = vts_pkg::ST_BLOCK;
						note_nxt = 1'b1;
					end else if (!pickup) begin
						st_nxt = vts_pkg::ST_IDLE; // release as on pick-up reset
					end else if (st_r == vts_pkg::ST_START && rem_r == '0) begin
						st_nxt = vts_pkg::ST_OPERATE;
					end
				end
				vts_pkg::ST_BLOCK: begin
					if (!blk_i || !pickup) begin
						st_nxt = vts_pkg::ST_IDLE;
					end
				end
				default: begin
					st_nxt = vts_pkg::ST_IDLE;
				end
			endcase
			act_nxt = {line_fuse_i && line_fuse_chk_i, bus_fuse_i && bus_fuse_chk_i, line_fail_i,
				st_nxt == vts_pkg::ST_BLOCK, st_nxt == vts_pkg::ST_OPERATE,
				st_nxt == vts_pkg::ST_START || st_nxt == vts_pkg::ST_OPERATE};
			for (int f = 0; f < vts_pkg::NUM_FAM; f++) begin
				// set wins over the drain clear
				pend_nxt[2*f] = pend_nxt[2*f] | (act_nxt[f] & ~act_r[f]);
				pend_nxt[2*f+1] = pend_nxt[2*f+1] | (act_r[f] & ~act_nxt[f]);
			end
			// process data captured with the transition
			snap_nxt.ts = ts_r;
			snap_nxt.vstat = vstat;
			snap_nxt.sys = (vstat == 6'h00) ? vts_pkg::SYS_DEAD : pickup ? vts_pkg::SYS_FAULT :
				vts_pkg::SYS_OK + ((seq_code_i == 2'h3) ? 3'h2 : {1'b0, seq_code_i});
			snap_nxt.angle = d_raw;
			snap_nxt.remain = rem_nxt;
			snap_nxt.grp = setting_group_index_i;
			// encoded condition
			if (act_nxt[2]) begin
				cond_nxt = vts_pkg::COND_BLOCKED;
			end else if (act_nxt[0]) begin
				cond_nxt = vts_pkg::COND_START;
			end else if (act_nxt[4]) begin
				cond_nxt = vts_pkg::COND_BUSFAIL;
			end else if (act_nxt[3] || act_nxt[5]) begin
				cond_nxt = vts_pkg::COND_LINEFAIL;
			end else begin
				cond_nxt = vts_pkg::COND_NORMAL;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			st_r <= vts_pkg::ST_IDLE;
			rem_r <= '0;
			act_r <= '0;
			pend_r <= '0;
			note_r <= 1'b0;
			cond_r <= vts_pkg::COND_NORMAL;
			snap_r <= '0;
			evt_r <= '0;
			evt_v_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			rem_r <= rem_nxt;
			act_r <= act_nxt;
			pend_r <= pend_nxt;
			note_r <= note_nxt;
			cond_r <= cond_nxt;
			snap_r <= snap_nxt;
			evt_r <= evt_nxt;
			evt_v_r <= evt_v_nxt;
		end
	end

	// history of on-transition records
	vts_history #(.DEPTH(vts_pkg::HIST_DEPTH)) u_hist (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.h(hif.store)
	);

	assign start_o = act_r[0];
	assign operate_o = act_r[1];
	assign blocked_o = act_r[2];
	assign display_note_o = note_r;
	assign condition_o = cond_r;
	assign remaining_ms_o = rem_r;
	assign evt_valid_o = evt_v_r;
	assign evt_rec_o = evt_r;
	assign hist_rec_o = hif.rd_rec;
	assign hist_count_o = hif.count;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_cycle_only: assert property (!cycle_tick_i |=> $stable(st_r)) else $error("state moved off tick");
	a_start_gate: assert property ($rose(start_o) |-> $past(cycle_tick_i && !blk_i && pickup))
		else $error("start without clear pick-up");
	a_block_excl: assert property (blocked_o |-> !start_o && !operate_o) else $error("start while blocked");
	a_block_drop: assert property (cycle_tick_i && start_o && blk_i |=> blocked_o && !start_o)
		else $error("start kept under blocking");
	a_note_pulse: assert property ($rose(blocked_o) |-> display_note_o ##1 !display_note_o)
		else $error("display note missing");
	a_oper_cause: assert property ($rose(operate_o) |-> $past(rem_r == '0 && start_o && !blk_i))
		else $error("operate before delay");
	a_evt_store: assert property (evt_valid_o |-> $past(evt_sel_i[sel])) else $error("masked event issued");
	a_cond_code: assert property (blocked_o |-> condition_o == vts_pkg::COND_BLOCKED)
		else $error("condition not blocked");
	c_operate: cover property ($rose(operate_o));
	c_start_blocked: cover property (start_o ##1 blocked_o);
	c_block_direct: cover property (!start_o ##1 blocked_o);
endmodule

// *** tb/vts_far_side.sv ***
// Purpose: blocking matrix source and event buffer sink facing the supervision block
// Assumes: requests come from the bench just after a rising edge
// Notes: remembers which codes arrived since the last clear and the last record
`timescale 1ns/10ps
module vts_far_side (
	input wire logic clk_sys_i, // system clock
	input wire logic clr_i, // forget seen codes
	input wire logic blk_req_i, // blocking wanted by the bench
	output logic blk_o, // blocking level to the block
	input wire logic evt_valid_i, // event strobe from the block
	input wire vts_pkg::hist_rec_t evt_rec_i, // event record from the block
	output logic [11:0] seen_o, // one bit per arrived code
	output vts_pkg::hist_rec_t last_o // most recent stored event
);
	// blocking is a level held across the tick, passed straight through from blk_req_i
	assign blk_o = blk_req_i;
	// event buffer: accept every strobe while clr_i is low, mark its code
	always_ff @(posedge clk_sys_i) begin
		if (clr_i) begin
			seen_o <= 12'h000;
		end else if (evt_valid_i) begin
			seen_o[evt_rec_i.code] <= 1'b1;
			last_o <= evt_rec_i;
		end
	end
endmodule

// *** tb/vt_supervision_block_event_log_bench.sv ***
// Purpose: self-checking bench of the supervision block with random pick-up cases
// Assumes: CLK_PER_MS shortened to 10, ticks spaced at least 1.8 ms (18 clocks) apart
// Notes: event drain and history write finish within the 16 clocks after each tick
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module vt_supervision_block_event_log_bench;
	logic clk_sys_i = 0, reset_i = 1, tick = 0, blk_req = 0, blk, clr = 1; // clock, reset, handshakes
	logic [2:0][15:0] v = '0; // voltage magnitudes
	logic [15:0] lo = 16'h0064, hi = 16'h03E8, alim = 16'h01F4; // thresholds and angle limit
	logic [20:0] dly = 21'h00_0003; // operate delay in ms
	logic lf = 0, bf = 0, lff = 0, bchk = 1, lchk = 1; // failure inputs and fuse gates
	logic [1:0] seq = 0; // sequence code
	logic [2:0] grp = 0; // setting group
	logic [15:0] ang = 16'h0000; // present angle, 0.01 deg
	logic [11:0] sel = 12'hFFF; // event store enables
	logic [3:0] ridx = 0, last_on = 4'hA; // history read index, newest on code
	logic st, op, bl, note_p, note, ev_v; // design outputs and captured pulse
	logic [2:0] cond; // condition code
	logic [20:0] rem, rm; // remaining time, captured after tick
	logic [3:0] hcnt; // history count
	logic [11:0] seen; // codes seen by far side
	vts_pkg::hist_rec_t ev_rec, h_rec, last; // records
	int errors = 0, n_checks = 0; // counters
	logic b, p; // random blocking and expected pick-up
	// free running 100 MHz clock
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	vts_top #(.CLK_PER_MS(10), .LAG(8)) i_vts_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.cycle_tick_i(tick), .blk_i(blk), .volt_mag_i(v), .low_thr_i(lo), .high_thr_i(hi),
		.angle_i(ang), .angle_limit_i(alim), .delay_ms_i(dly), .line_fail_i(lf),
		.bus_fuse_i(bf), .line_fuse_i(lff), .bus_fuse_chk_i(bchk), .line_fuse_chk_i(lchk),
		.seq_code_i(seq), .setting_group_index_i(grp), .evt_sel_i(sel), .hist_rd_idx_i(ridx),
		.start_o(st), .operate_o(op), .blocked_o(bl), .display_note_o(note_p), .condition_o(cond),
		.remaining_ms_o(rem), .evt_valid_o(ev_v), .evt_rec_o(ev_rec), .hist_rec_o(h_rec),
		.hist_count_o(hcnt));
	vts_far_side i_vts_far_side (.clk_sys_i(clk_sys_i), .clr_i(clr), .blk_req_i(blk_req),
		.blk_o(blk), .evt_valid_i(ev_v), .evt_rec_i(ev_rec), .seen_o(seen), .last_o(last));
	// expected pick-up: one voltage low or two high
	function automatic logic pk(input logic [2:0][15:0] vv);
		int nl, nh;
		nl = 0;
		nh = 0;
		for (int k = 0; k < 3; k++) begin
			if (vv[k] < lo) nl++;
			if (vv[k] > hi) nh++;
		end
		return (nl > 0) || (nh >= 2);
	endfunction
	// one program cycle; blocking flips afterwards to show it is read only at the tick
	task automatic tk(input logic bb);
		@(posedge clk_sys_i);
		#1;
		tick = 1;
		blk_req = bb;
		clr = 1;
		@(posedge clk_sys_i);
		#1;
		tick = 0;
		clr = 0;
		note = note_p;
		rm = rem;
		blk_req = ~bb;
		repeat (16) @(posedge clk_sys_i);
		#1;
	endtask
	// verdict and end of run
	task automatic end_sim;
		$display("errors=%0d n_checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// hang guard
	initial begin
		#1000000;
		errors++;
		end_sim();
	end
	// main sequence
	initial begin
		void'($urandom(32'h030a_ad52));
		repeat (20) @(posedge clk_sys_i);
		#1;
		reset_i = 0;
		`CHK("cond_reset", 3'h0, cond);
		v = {16'h01F4, 16'h01F4, 16'h000A};
		tk(0);
		`CHK("start_angle", 1'b0, st);
		alim = 16'h0000;
		sel = 12'hFFE;
		tk(0);
		`CHK("start", 1'b1, st);
		`CHK("cond_start", 3'h1, cond);
		`CHK("remain", 21'h00_0003, rm);
		`CHK("start_on_refused", 1'b0, seen[0]);
		`CHK("hist_cnt1", 4'h1, hcnt);
		sel = 12'hFFF;
		repeat (20) @(posedge clk_sys_i);
		tk(0);
		`CHK("operate", 1'b1, op);
		`CHK("oper_on", 1'b1, seen[2]);
		`CHK("vstat", 6'h16, last.vstat);
		`CHK("sys", 3'h4, last.sys);
		`CHK("grp", grp, last.grp);
		`CHK("hist_cnt2", 4'h2, hcnt);
		tk(1);
		`CHK("blocked", 1'b1, bl);
		`CHK("start_drop", 1'b0, st);
		`CHK("oper_drop", 1'b0, op);
		`CHK("note", 1'b1, note);
		`CHK("cond_blk", 3'h4, cond);
		`CHK("blk_codes", 12'h01A, seen);
		// block arrives long before a 20 ms delay ends: operate never follows
		v = {3{16'h01F4}};
		dly = 21'h00_0014;
		tk(0);
		v = {16'h01F4, 16'h01F4, 16'h000A};
		tk(0);
		tk(1);
		repeat (250) @(posedge clk_sys_i);
		tk(1);
		`CHK("no_operate", 1'b0, op);
		// failure inputs: condition code and their on events
		for (int k = 0; k < 3; k++) begin
			v = {3{16'h01F4}};
			{lff, bf, lf} = 3'b001 << k;
			seq = 2'(k);
			tk(0);
			`CHK("cond_fail", (k == 1) ? 3'h3 : 3'h2, cond);
			`CHK("sys_seq", 3'(k + 1), last.sys);
			`CHK("fail_on", 1'b1, seen[6 + 2 * k]);
		end
		{lff, bf, lf} = 3'b000;
		// random pick-up and blocking from idle
		for (int i = 0; i < 30; i++) begin
			v = {3{16'h01F4}};
			tk(0);
			for (int k = 0; k < 3; k++) v[k] = 16'($urandom_range(1400));
			b = 1'($urandom);
			grp = 3'($urandom);
			seq = 2'($urandom_range(2));
			p = pk(v);
			tk(b);
			`CHK("start_rnd", p && !b, st);
			`CHK("blocked_rnd", p && b, bl);
			`CHK("cond_rnd", p ? (b ? 3'h4 : 3'h1) : 3'h0, cond);
			if (p) begin
				last_on = b ? 4'h4 : 4'h0;
				`CHK("on_evt", 1'b1, seen[last_on]);
				`CHK("grp_rnd", grp, last.grp);
			end
		end
		ridx = 4'h0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("hist_full", 4'hC, hcnt);
		`CHK("hist_newest", last_on, h_rec.code);
		ridx = 4'hC;
		repeat (2) @(posedge clk_sys_i);
		#1;
		`CHK("hist_beyond", '0, h_rec);
		// angle gate: a step near 360 deg wraps to a small change, a 50 deg step passes
		v = {3{16'h01F4}};
		alim = 16'h01F4;
		tk(0);
		v = {16'h01F4, 16'h01F4, 16'h000A};
		ang = 16'h8C00;
		tk(0);
		`CHK("angle_wrap", 1'b0, st);
		ang = 16'h1388;
		tk(0);
		`CHK("angle_step", 1'b1, st);
		`CHK("angle_rec", 16'h1388, last.angle);
		`CHK("remain_rec", 21'h00_0014, last.remain);
		end_sim();
	end
endmodule
